// >>> logic/hub_boot_mode_sequencer.sv
// boot stage sequencer of a multi-port usb hub controller
// assumes straps and pins synchronous to i_core_clk; spi engine answers done
// Functional notes
// - reset low: standby, ports high-z, pll halted
// - standby disables ports, clears all settings
// - reset high: hub mode through boot stages
// - first stage resets, locks pll, loads defaults
// - spi strap: probe flash signature at top
// - valid signature runs flash, else internal rom
// - no spi strap skips probe to rom
// - flash supports single, dual, modes 0 and 3
// - config read: rom defaults then strap override
// - smbus target strap plus pull-ups: soc stage
// - soc stage waits with no timeout
// - otp merge combines rom, soc, otp data
// - configured: idle then suspend without vbus
// - vbus: charger detect if enabled, else connect
// - connect after charger detect, held while vbus
// - normal mode holds until system changes mode or vbus drops
// - otp over usb at runtime, smbus soc only
// - usb host may override battery charging
// - target strap with both pull-ups makes smbus a configuration target
module hub_boot_mode_sequencer (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_spi_strap,
    input wire logic [2:0] i_iface_strap,
    input wire logic i_mgmt_serial_data_pin,
    input wire logic i_mgmt_serial_clock_pin,
    input wire logic i_pll_clk_valid,
    input wire logic i_pll_locked,
    input wire logic i_flash_dual,
    input wire logic i_flash_mode3,
    input wire logic i_flash_done,
    input wire logic [31:0] i_flash_data,
    input wire hub_boot_pkg::cfg_src_t i_cfg_src,
    input wire logic i_soc_wr,
    input wire logic [7:0] i_soc_wr_addr,
    input wire logic i_vbus,
    input wire logic i_bc_enable,
    input wire logic i_chg_det_done,
    input wire logic i_host_bc_wr,
    input wire logic i_host_bc_val,
    input wire logic i_host_otp_req,
    input wire logic i_smb_otp_req,
    input wire logic i_mode_change,
    output logic [10:0] o_stage,
    output logic o_pll_run,
    output logic o_ports_enable,
    output logic o_flash_exec,
    output logic [15:0] o_exec_addr,
    output hub_boot_pkg::flash_req_t o_flash_req,
    output logic o_smb_target,
    output logic [15:0] o_cfg,
    output logic o_cfg_valid,
    output logic o_suspend,
    output logic o_usb_connect,
    output logic o_otp_grant_usb,
    output logic o_otp_grant_smb,
    output logic o_bc_active
);
    // reset synchroniser, first stage read only by the second
    logic rst_meta_q;
    logic rst_sync_q;

    // stage register and its next value
    hub_boot_pkg::stage_t stage_q;
    hub_boot_pkg::stage_t stage_d;
    // pll lock wait counter
    logic [7:0] lock_cnt_q;
    // smbus pull-up decision latched once
    logic smb_pullup_q;
    // merged configuration staging
    logic [15:0] cfg_q;
    // battery charging enable, host may override
    logic bc_en_q;
    // flash request has been issued
    logic probe_sent_q;

    // applies an override word under its enable mask
    function automatic logic [15:0] overlay(input logic [15:0] base,
                                            input logic [15:0] val,
                                            input logic [15:0] en);
        overlay = (base & ~en) | (val & en);
    endfunction : overlay

    // decode of strap and pin conditions
    wire strap_target = (i_iface_strap == hub_boot_pkg::SMB_TARGET_CODE);
    wire both_pullups = i_mgmt_serial_data_pin & i_mgmt_serial_clock_pin;
    wire sig_ok = (i_flash_data == hub_boot_pkg::FLASH_SIG);
    wire end_cfg_wr = i_soc_wr & (i_soc_wr_addr == hub_boot_pkg::END_CFG_REG);
    wire lock_done = (lock_cnt_q == hub_boot_pkg::PLL_LOCK_CNT);
    wire [15:0] cfg_rd_val = overlay(i_cfg_src.rom, i_cfg_src.strap, i_cfg_src.strap_en);
    wire [15:0] cfg_soc_val = overlay(cfg_q, i_cfg_src.soc, i_cfg_src.soc_en);
    wire [15:0] cfg_merge = overlay(cfg_soc_val, i_cfg_src.otp, i_cfg_src.otp_en);

    // synchronise chip reset release
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // next stage selection
    always_comb begin
        stage_d = stage_q;
        case (stage_q)
            hub_boot_pkg::ST_STANDBY: begin
                if (rst_sync_q) stage_d = hub_boot_pkg::ST_INIT;
            end
            hub_boot_pkg::ST_INIT: begin
                // wait for lock; with no valid clock stay here
                if (lock_done && i_pll_locked) begin
                    if (i_spi_strap) stage_d = hub_boot_pkg::ST_SPI;
                    else stage_d = hub_boot_pkg::ST_CFG_RD;
                end
            end
            hub_boot_pkg::ST_SPI: begin
                // signature miss falls back to rom config read
                if (i_flash_done && !sig_ok) stage_d = hub_boot_pkg::ST_CFG_RD;
            end
            hub_boot_pkg::ST_CFG_RD: stage_d = hub_boot_pkg::ST_STRAP;
            hub_boot_pkg::ST_STRAP: begin
                if (strap_target && both_pullups) stage_d = hub_boot_pkg::ST_SOC_CFG;
                else stage_d = hub_boot_pkg::ST_OTP_CFG;
            end
            hub_boot_pkg::ST_SOC_CFG: begin
                // no timeout: only the end write leaves
                if (end_cfg_wr) stage_d = hub_boot_pkg::ST_OTP_CFG;
            end
            hub_boot_pkg::ST_OTP_CFG: stage_d = hub_boot_pkg::ST_IDLE;
            hub_boot_pkg::ST_IDLE: begin
                if (i_vbus && bc_en_q) stage_d = hub_boot_pkg::ST_CHG_DET;
                else if (i_vbus) stage_d = hub_boot_pkg::ST_CONNECT;
            end
            hub_boot_pkg::ST_CHG_DET: begin
                if (i_chg_det_done) stage_d = hub_boot_pkg::ST_CONNECT;
            end
            hub_boot_pkg::ST_CONNECT: begin
                if (!i_vbus) stage_d = hub_boot_pkg::ST_IDLE;
                else stage_d = hub_boot_pkg::ST_NORMAL;
            end
            hub_boot_pkg::ST_NORMAL: begin
                // only a system mode change or vbus loss leaves
                if (i_mode_change || !i_vbus) stage_d = hub_boot_pkg::ST_IDLE;
            end
            default: stage_d = hub_boot_pkg::ST_STANDBY;
        endcase
    end

    // stage register, standby while synchronised reset is low
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) stage_q <= hub_boot_pkg::ST_STANDBY;
        else if (!rst_sync_q) stage_q <= hub_boot_pkg::ST_STANDBY;
        else stage_q <= stage_d;
    end

    // pll lock counter runs only in init with a valid clock
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) lock_cnt_q <= 8'h00;
        else if (stage_q != hub_boot_pkg::ST_INIT || !i_pll_clk_valid) lock_cnt_q <= 8'h00;
        else if (!lock_done) lock_cnt_q <= lock_cnt_q + 8'h01;
    end

    // configuration build and one-time pull-up decision
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_q <= hub_boot_pkg::CFG_RESET;
            smb_pullup_q <= 1'b0;
            bc_en_q <= 1'b0;
            probe_sent_q <= 1'b0;
        end else begin
            if (stage_q == hub_boot_pkg::ST_INIT) cfg_q <= hub_boot_pkg::CFG_RESET;
            if (stage_q == hub_boot_pkg::ST_CFG_RD) cfg_q <= cfg_rd_val;
            if (stage_q == hub_boot_pkg::ST_OTP_CFG) cfg_q <= cfg_merge;
            if (stage_q == hub_boot_pkg::ST_STRAP) begin
                smb_pullup_q <= strap_target & both_pullups;
            end
            if (stage_q == hub_boot_pkg::ST_OTP_CFG) bc_en_q <= i_bc_enable;
            else if (i_host_bc_wr && stage_q == hub_boot_pkg::ST_NORMAL) begin
                bc_en_q <= i_host_bc_val;
            end
            probe_sent_q <= (stage_q == hub_boot_pkg::ST_SPI);
        end
    end

    // registered outputs
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_stage <= hub_boot_pkg::ST_STANDBY;
            o_pll_run <= 1'b0;
            o_ports_enable <= 1'b0;
            o_flash_exec <= 1'b0;
            o_exec_addr <= hub_boot_pkg::EXEC_ADDR;
            o_flash_req <= '0;
            o_smb_target <= 1'b0;
            o_cfg <= hub_boot_pkg::CFG_RESET;
            o_cfg_valid <= 1'b0;
            o_suspend <= 1'b0;
            o_usb_connect <= 1'b0;
            o_otp_grant_usb <= 1'b0;
            o_otp_grant_smb <= 1'b0;
            o_bc_active <= 1'b0;
        end else begin
            o_stage <= stage_d;
            o_pll_run <= rst_sync_q & i_pll_clk_valid;
            o_ports_enable <= (stage_d == hub_boot_pkg::ST_NORMAL) ||
                              (stage_d == hub_boot_pkg::ST_CONNECT);
            if (stage_q == hub_boot_pkg::ST_SPI && i_flash_done && sig_ok) begin
                o_flash_exec <= 1'b1;
                o_exec_addr <= hub_boot_pkg::EXEC_ADDR;
            end else if (stage_q == hub_boot_pkg::ST_STANDBY) begin
                o_flash_exec <= 1'b0;
            end
            o_flash_req.req <= (stage_q == hub_boot_pkg::ST_SPI) & ~probe_sent_q;
            o_flash_req.addr <= hub_boot_pkg::SIG_ADDR;
            o_flash_req.dual <= i_flash_dual;
            o_flash_req.mode3 <= i_flash_mode3;
            o_smb_target <= smb_pullup_q;
            o_cfg <= cfg_q;
            o_cfg_valid <= (stage_q == hub_boot_pkg::ST_IDLE) ||
                           (stage_q == hub_boot_pkg::ST_CHG_DET) ||
                           (stage_q == hub_boot_pkg::ST_CONNECT) ||
                           (stage_q == hub_boot_pkg::ST_NORMAL);
            o_suspend <= (stage_d == hub_boot_pkg::ST_IDLE) & ~i_vbus;
            o_usb_connect <= i_vbus & ((stage_d == hub_boot_pkg::ST_CONNECT) ||
                             (stage_d == hub_boot_pkg::ST_NORMAL));
            o_otp_grant_usb <= i_host_otp_req & (stage_q == hub_boot_pkg::ST_NORMAL);
            o_otp_grant_smb <= i_smb_otp_req & (stage_q == hub_boot_pkg::ST_SOC_CFG);
            o_bc_active <= bc_en_q & (stage_d == hub_boot_pkg::ST_CHG_DET);
        end
    end

    // standby after reset holds ports off and the stage in standby
    standby_hold_a: assert property (@(posedge i_core_clk)
        !rst_sync_q |=> (!o_ports_enable && stage_q == hub_boot_pkg::ST_STANDBY))
        else $error("standby not held");
    // release of reset enters init within three edges
    release_init_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(rst_sync_q) |-> stage_q == hub_boot_pkg::ST_STANDBY ##1
        stage_q == hub_boot_pkg::ST_INIT)
        else $error("init not entered after release");
    // init never leaves before the lock count
    init_lock_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (stage_q == hub_boot_pkg::ST_INIT && !lock_done) |=>
        (stage_q inside {hub_boot_pkg::ST_INIT, hub_boot_pkg::ST_STANDBY}))
        else $error("left init before lock");
    // no spi strap skips the probe
    skip_probe_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (stage_q == hub_boot_pkg::ST_INIT && stage_d != stage_q && !i_spi_strap) |=>
        stage_q == hub_boot_pkg::ST_CFG_RD)
        else $error("probe not skipped");
    // valid signature turns on flash execution at start address
    flash_exec_a: assert property (@(posedge i_core_clk) disable iff (!rst_sync_q)
        (stage_q == hub_boot_pkg::ST_SPI && i_flash_done && sig_ok) |=>
        (o_flash_exec && o_exec_addr == hub_boot_pkg::EXEC_ADDR))
        else $error("flash execution not enabled");
    // strap stage branches on the target strap and pull-ups
    strap_branch_a: assert property (@(posedge i_core_clk) disable iff (!rst_sync_q)
        stage_q == hub_boot_pkg::ST_STRAP |=>
        stage_q == ($past(strap_target && both_pullups) ? hub_boot_pkg::ST_SOC_CFG
                                                   : hub_boot_pkg::ST_OTP_CFG))
        else $error("strap branch wrong");
    // soc stage holds until the end register write
    soc_wait_a: assert property (@(posedge i_core_clk) disable iff (!rst_sync_q)
        (stage_q == hub_boot_pkg::ST_SOC_CFG && !end_cfg_wr) |=>
        stage_q == hub_boot_pkg::ST_SOC_CFG)
        else $error("soc stage left early");
    // vbus from idle picks charger detect only with charging on
    vbus_branch_a: assert property (@(posedge i_core_clk) disable iff (!rst_sync_q)
        (stage_q == hub_boot_pkg::ST_IDLE && i_vbus) |=>
        stage_q == ($past(bc_en_q) ? hub_boot_pkg::ST_CHG_DET : hub_boot_pkg::ST_CONNECT))
        else $error("vbus branch wrong");
    // smbus otp grant only in soc stage
    otp_smb_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_otp_grant_smb |-> $past(stage_q) == hub_boot_pkg::ST_SOC_CFG)
        else $error("smbus otp grant outside soc stage");
    // probe request names the signature address, only from the spi stage
    probe_addr_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_flash_req.req |->
        (o_flash_req.addr == hub_boot_pkg::SIG_ADDR && $past(stage_q) == hub_boot_pkg::ST_SPI))
        else $error("bad flash probe request");
    // transfer width and clock mode follow the flash straps
    flash_mode_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_flash_req.req |->
        (o_flash_req.dual == $past(i_flash_dual) && o_flash_req.mode3 == $past(i_flash_mode3)))
        else $error("flash transfer mode lost");
    // config read loads rom defaults under strap overrides
    cfg_read_a: assert property (@(posedge i_core_clk) disable iff (!rst_sync_q)
        stage_q == hub_boot_pkg::ST_CFG_RD |=>
        cfg_q == $past(cfg_rd_val))
        else $error("config read not loaded");
    // merge applies soc and otp words, then goes idle
    otp_merge_a: assert property (@(posedge i_core_clk) disable iff (!rst_sync_q)
        stage_q == hub_boot_pkg::ST_OTP_CFG |=>
        (cfg_q == $past(cfg_merge) && stage_q == hub_boot_pkg::ST_IDLE))
        else $error("merge not applied");
    // idle without vbus reports suspend
    suspend_a: assert property (@(posedge i_core_clk) disable iff (!rst_sync_q)
        (stage_d == hub_boot_pkg::ST_IDLE && !i_vbus) |=>
        o_suspend)
        else $error("suspend missing in idle");
    // finished charger detection moves to upstream connect
    chg_done_a: assert property (@(posedge i_core_clk) disable iff (!rst_sync_q)
        (stage_q == hub_boot_pkg::ST_CHG_DET && i_chg_det_done) |=>
        stage_q == hub_boot_pkg::ST_CONNECT)
        else $error("charger detect did not end");
    // usb connect only while vbus is present
    connect_vbus_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_usb_connect |->
        $past(i_vbus))
        else $error("connect without vbus");
    // normal mode holds while vbus stays and no mode change comes
    normal_hold_a: assert property (@(posedge i_core_clk) disable iff (!rst_sync_q)
        (stage_q == hub_boot_pkg::ST_NORMAL && i_vbus && !i_mode_change) |=>
        stage_q == hub_boot_pkg::ST_NORMAL)
        else $error("normal mode left early");
    // usb otp grant only in normal operation
    otp_usb_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_otp_grant_usb |->
        $past(stage_q) == hub_boot_pkg::ST_NORMAL)
        else $error("usb otp grant outside normal");
    // host override of charging lands in normal mode
    host_bc_a: assert property (@(posedge i_core_clk) disable iff (!rst_sync_q)
        (i_host_bc_wr && stage_q == hub_boot_pkg::ST_NORMAL) |=>
        bc_en_q == $past(i_host_bc_val))
        else $error("charging override lost");
    // pull-up decision changes only in the strap stage
    pullup_hold_a: assert property (@(posedge i_core_clk) disable iff (!rst_sync_q)
        stage_q != hub_boot_pkg::ST_STRAP |=>
        $stable(smb_pullup_q))
        else $error("pull-up decision changed");
endmodule : hub_boot_mode_sequencer

// >>> common/hub_boot_pkg.sv
// package for the hub boot mode sequencer: stage codes, carriers, constants
// assumes a single 20 MHz core clock and synchronous strap and pin inputs
package hub_boot_pkg;
    // one-hot boot stage codes
    typedef enum logic [10:0] {
        ST_STANDBY  = 11'h001, // chip reset held
        ST_INIT     = 11'h002, // internal init, pll lock
        ST_SPI      = 11'h004, // flash signature probe
        ST_CFG_RD   = 11'h008, // rom defaults then strap override
        ST_STRAP    = 11'h010, // interface strap and pull-up sample
        ST_SOC_CFG  = 11'h020, // soc configures over smbus
        ST_OTP_CFG  = 11'h040, // merge of all configuration
        ST_IDLE     = 11'h080, // configured, waiting for vbus
        ST_CHG_DET  = 11'h100, // charger_detect_stage
        ST_CONNECT  = 11'h200, // upstream connect
        ST_NORMAL   = 11'h400  // full usb operation
    } stage_t;

    // firmware signature stored in flash, ascii text
    localparam logic [31:0] FLASH_SIG = 32'h3244_4655;
    // byte address of the signature in flash
    localparam logic [15:0] SIG_ADDR = 16'hFFFA;
    // execution start address when flash is used
    localparam logic [15:0] EXEC_ADDR = 16'h0000;
    // end-of-configuration register written by the soc
    localparam logic [7:0] END_CFG_REG = 8'hFF;
    // interface strap code for smbus target setting
    localparam logic [2:0] SMB_TARGET_CODE = 3'h2;
    // pll lock wait, in ns, and derived cycles at 50 ns
    localparam int PLL_LOCK_NS = 1000;
    localparam int CLK_NS = 50;
    localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] PLL_LOCK_CNT = 8'(PLL_LOCK_CYC);
    // reset values of configuration words
    localparam logic [15:0] CFG_RESET = 16'h0000;

    // flash probe request to the spi engine
    typedef struct packed {
        logic        req;      // start a read
        logic [15:0] addr;     // flash byte address
        logic        dual;     // dual-bit transfer
        logic        mode3;    // clock mode 3 rather than 0
    } flash_req_t;

    // configuration contributions
    typedef struct packed {
        logic [15:0] rom;      // internal rom defaults
        logic [15:0] strap;    // strap override values
        logic [15:0] strap_en; // which bits straps override
        logic [15:0] soc;      // soc written values
        logic [15:0] soc_en;   // which bits soc wrote
        logic [15:0] otp;      // otp values
        logic [15:0] otp_en;   // which bits otp programs
    } cfg_src_t;
endpackage : hub_boot_pkg

// >>> dv/hub_far_side_model.sv
// far side model: spi flash answering the signature read, soc ending its setup
// assumes the sequencer's flash request pulse and a bench-driven soc start
module hub_far_side_model (
    input wire logic i_core_clk,
    input wire hub_boot_pkg::flash_req_t i_flash_req,
    input wire logic i_sig_good,
    input wire logic i_soc_go,
    output logic o_flash_done,
    output logic [31:0] o_flash_data,
    output logic o_soc_wr,
    output logic [7:0] o_soc_wr_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus values at time zero
    initial begin
        o_flash_done = 1'h0;
        o_flash_data = 32'h0;
        o_soc_wr = 1'h0;
        o_soc_wr_addr = 8'h00;
    end
    // flash answers a read after a few cycles; the data bus wanders afterwards
    always @(posedge i_core_clk) begin
        if (i_flash_req.req === 1'h1) begin
            repeat (4) @(negedge i_core_clk);
            o_flash_data <= i_sig_good ? hub_boot_pkg::FLASH_SIG : 32'h3244_4600;
            o_flash_done <= 1'h1;
            @(negedge i_core_clk);
            o_flash_done <= 1'h0;
            o_flash_data <= ~o_flash_data;
        end
    end
    // soc writes one setting, then the end-of-configuration register
    always @(posedge i_soc_go) begin
        @(negedge i_core_clk);
        o_soc_wr <= 1'h1;
        o_soc_wr_addr <= 8'h10;
        @(negedge i_core_clk);
        o_soc_wr <= 1'h0;
        @(negedge i_core_clk);
        o_soc_wr <= 1'h1;
        o_soc_wr_addr <= hub_boot_pkg::END_CFG_REG;
        @(negedge i_core_clk);
        o_soc_wr <= 1'h0;
        o_soc_wr_addr <= 8'h00;
    end
endmodule : hub_far_side_model

// >>> dv/tb.sv
// bench for the boot stage sequencer: walks every boot path through resets
// assumes the far side model drives flash answers and soc writes
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_core_clk = 1'h0, i_rst_n = 1'h0, i_spi_strap = 1'h0;
    logic [2:0] i_iface_strap = 3'h0;
    logic i_mgmt_serial_data_pin = 1'h1, i_mgmt_serial_clock_pin = 1'h1;
    logic i_pll_clk_valid = 1'h1, i_pll_locked = 1'h1, i_flash_dual = 1'h0;
    logic i_flash_mode3 = 1'h0, i_flash_done, i_soc_wr, i_vbus = 1'h0;
    logic [31:0] i_flash_data;
    logic [7:0] i_soc_wr_addr;
    logic i_bc_enable = 1'h0, i_chg_det_done = 1'h0, i_host_bc_wr = 1'h0;
    logic i_host_bc_val = 1'h0, i_host_otp_req = 1'h0, i_smb_otp_req = 1'h0;
    logic i_mode_change = 1'h0, sig_good = 1'h0, soc_go = 1'h0;
    hub_boot_pkg::cfg_src_t i_cfg_src = '{16'h1234, 16'hAB00, 16'hFF00,
        16'h00CD, 16'h0000, 16'h0005, 16'h000F};
    logic [10:0] o_stage;
    logic [15:0] o_exec_addr, o_cfg;
    logic o_pll_run, o_ports_enable, o_flash_exec, o_smb_target, o_cfg_valid;
    logic o_suspend, o_usb_connect, o_otp_grant_usb, o_otp_grant_smb, o_bc_active;
    hub_boot_pkg::flash_req_t o_flash_req, seen_req = '0;
    int mismatches = 0, tests_run = 0;
    always #25 i_core_clk = ~i_core_clk; // 20 MHz
    hub_boot_mode_sequencer uut (.i_core_clk, .i_rst_n, .i_spi_strap, .i_iface_strap,
        .i_mgmt_serial_data_pin, .i_mgmt_serial_clock_pin, .i_pll_clk_valid,
        .i_pll_locked, .i_flash_dual, .i_flash_mode3, .i_flash_done, .i_flash_data,
        .i_cfg_src, .i_soc_wr, .i_soc_wr_addr, .i_vbus, .i_bc_enable, .i_chg_det_done,
        .i_host_bc_wr, .i_host_bc_val, .i_host_otp_req, .i_smb_otp_req, .i_mode_change,
        .o_stage, .o_pll_run, .o_ports_enable, .o_flash_exec, .o_exec_addr,
        .o_flash_req, .o_smb_target, .o_cfg, .o_cfg_valid, .o_suspend, .o_usb_connect,
        .o_otp_grant_usb, .o_otp_grant_smb, .o_bc_active);
    hub_far_side_model far (.i_core_clk(i_core_clk), .i_flash_req(o_flash_req),
        .i_sig_good(sig_good), .i_soc_go(soc_go), .o_flash_done(i_flash_done),
        .o_flash_data(i_flash_data), .o_soc_wr(i_soc_wr), .o_soc_wr_addr(i_soc_wr_addr));
    // keeps the last flash request so its fields can be checked later
    always @(posedge i_core_clk) begin
        if (o_flash_req.req === 1'h1) begin
            seen_req <= o_flash_req;
        end
    end
    // expected merge: rom, strap overlay, soc, then otp under their masks
    function automatic logic [15:0] merge(input hub_boot_pkg::cfg_src_t s);
        logic [15:0] v;
        v = (s.rom & ~s.strap_en) | (s.strap & s.strap_en);
        v = (v & ~s.soc_en) | (s.soc & s.soc_en);
        merge = (v & ~s.otp_en) | (s.otp & s.otp_en);
    endfunction : merge
    task automatic go(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask : go
    task automatic chk_bit(input logic g, input logic e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t bit got %b want %b", $time, g, e);
        end
    endtask : chk_bit
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t word got %h want %h", $time, g, e);
        end
    endtask : chk_word
    // waits a bounded number of cycles for a stage code
    task automatic wait_stage(input logic [10:0] s, input int n);
        int i;
        i = 0;
        while (o_stage !== s && i < n) begin
            @(negedge i_core_clk);
            i++;
        end
        tests_run++;
        if (o_stage !== s) begin
            mismatches++;
            $display("BAD %0t stage %h want %h", $time, o_stage, s);
        end
    endtask : wait_stage
    // holds reset 6 cycles and checks the standby state meanwhile
    task automatic do_reset();
        @(negedge i_core_clk);
        i_rst_n = 1'h0;
        go(5);
        wait_stage(hub_boot_pkg::ST_STANDBY, 0);
        chk_bit(o_pll_run, 1'h0);
        chk_bit(o_ports_enable, 1'h0);
        chk_bit(o_cfg_valid, 1'h0);
        go(1);
        i_rst_n = 1'h1;
    endtask : do_reset
    task automatic end_sim();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    // watchdog well past the expected few hundred cycles
    initial begin
        #(8000 * 50);
        mismatches++;
        end_sim();
    end
    initial begin
        // plain boot from internal rom, then connect without charging
        do_reset();
        wait_stage(hub_boot_pkg::ST_INIT, 10);
        wait_stage(hub_boot_pkg::ST_CFG_RD, 40);
        wait_stage(hub_boot_pkg::ST_STRAP, 2);
        wait_stage(hub_boot_pkg::ST_OTP_CFG, 2);
        wait_stage(hub_boot_pkg::ST_IDLE, 2);
        go(3);
        chk_bit(seen_req.req, 1'h0);
        chk_bit(o_pll_run, 1'h1);
        chk_bit(o_cfg_valid, 1'h1);
        chk_word(o_cfg, merge(i_cfg_src));
        chk_bit(o_suspend, 1'h1);
        i_vbus = 1'h1;
        wait_stage(hub_boot_pkg::ST_CONNECT, 4);
        go(1);
        chk_bit(o_usb_connect, 1'h1);
        wait_stage(hub_boot_pkg::ST_NORMAL, 4);
        i_host_otp_req = 1'h1;
        i_smb_otp_req = 1'h1;
        i_host_bc_wr = 1'h1;
        i_host_bc_val = 1'h1;
        go(1);
        i_host_bc_wr = 1'h0;
        go(2);
        chk_bit(o_otp_grant_usb, 1'h1);
        chk_bit(o_otp_grant_smb, 1'h0);
        i_mode_change = 1'h1;
        wait_stage(hub_boot_pkg::ST_IDLE, 4);
        i_mode_change = 1'h0;
        wait_stage(hub_boot_pkg::ST_CHG_DET, 4);
        chk_bit(o_bc_active, 1'h1);
        i_vbus = 1'h0;
        // flash probe with a bad signature falls back to rom
        i_spi_strap = 1'h1;
        i_flash_dual = 1'h1;
        i_flash_mode3 = 1'h1;
        do_reset();
        wait_stage(hub_boot_pkg::ST_SPI, 40);
        wait_stage(hub_boot_pkg::ST_CFG_RD, 12);
        chk_word(seen_req.addr, hub_boot_pkg::SIG_ADDR);
        chk_bit(seen_req.dual, 1'h1);
        chk_bit(seen_req.mode3, 1'h1);
        // good signature runs from flash start
        sig_good = 1'h1;
        i_flash_dual = 1'h0;
        i_flash_mode3 = 1'h0;
        do_reset();
        wait_stage(hub_boot_pkg::ST_SPI, 40);
        go(10);
        chk_bit(o_flash_exec, 1'h1);
        chk_word(o_exec_addr, hub_boot_pkg::EXEC_ADDR);
        chk_bit(seen_req.dual, 1'h0);
        chk_bit(seen_req.mode3, 1'h0);
        // smbus target strap with both pull-ups waits for the soc
        i_spi_strap = 1'h0;
        i_iface_strap = hub_boot_pkg::SMB_TARGET_CODE;
        i_cfg_src.soc_en = 16'h00F0;
        i_bc_enable = 1'h1;
        do_reset();
        wait_stage(hub_boot_pkg::ST_SOC_CFG, 40);
        go(2);
        chk_bit(o_smb_target, 1'h1);
        chk_bit(o_otp_grant_smb, 1'h1);
        chk_bit(o_otp_grant_usb, 1'h0);
        go(300);
        wait_stage(hub_boot_pkg::ST_SOC_CFG, 0);
        soc_go = 1'h1;
        wait_stage(hub_boot_pkg::ST_OTP_CFG, 10);
        wait_stage(hub_boot_pkg::ST_IDLE, 2);
        go(3);
        chk_word(o_cfg, merge(i_cfg_src));
        chk_bit(o_otp_grant_smb, 1'h0);
        i_vbus = 1'h1;
        wait_stage(hub_boot_pkg::ST_CHG_DET, 4);
        i_chg_det_done = 1'h1;
        wait_stage(hub_boot_pkg::ST_CONNECT, 4);
        i_chg_det_done = 1'h0;
        i_vbus = 1'h0;
        wait_stage(hub_boot_pkg::ST_IDLE, 4);
        // one missing pull-up skips the soc stage
        soc_go = 1'h0;
        i_mgmt_serial_clock_pin = 1'h0;
        do_reset();
        wait_stage(hub_boot_pkg::ST_STRAP, 40);
        wait_stage(hub_boot_pkg::ST_OTP_CFG, 2);
        end_sim();
    end
endmodule : tb
